// file: design/strap_pkg.sv
// Constants, field layouts and types shared by the strap decoder files.
package strap_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 10;
	localparam int SETTLE_TIME_NS = 200;
	localparam int SETTLE_CYCLES  =
		(SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W       = 8;
	localparam logic [SETTLE_W-1:0] SETTLE_RST = SETTLE_W'(SETTLE_CYCLES);
	localparam logic [SETTLE_W-1:0] SETTLE_ZERO = '0;

	// ------------------------------------------------------------------
	// Strap pins
	// ------------------------------------------------------------------
	localparam int NUM_STRAPS   = 6;
	localparam int IDX_MODE_PRI = 0;
	localparam int IDX_MODE_SEC = 1;
	localparam int IDX_RANGE    = 2;
	localparam int IDX_SWING    = 3;
	localparam int IDX_EDGE     = 4;
	localparam int IDX_CAL      = 5;

	typedef enum logic [1:0] {
		LVL_LOW,
		LVL_HIGH,
		LVL_FLOAT
	} strap_level_e;

	typedef strap_level_e [NUM_STRAPS-1:0] strap_levels_t;

	// ------------------------------------------------------------------
	// Wishbone register map
	// ------------------------------------------------------------------
	localparam int WB_ADR_W = 8;
	localparam int WB_DAT_W = 32;
	localparam int WB_SEL_W = 4;
	localparam logic [WB_ADR_W-1:0] OFS_CTRL     = 8'h00;
	localparam logic [WB_ADR_W-1:0] OFS_STATUS   = 8'h04;
	localparam logic [WB_ADR_W-1:0] OFS_SETTLE   = 8'h08;
	localparam logic [WB_ADR_W-1:0] OFS_SETTINGS = 8'h0c;

	localparam int CTRL_RESENSE_BIT = 0;

	localparam int ST_EXT_BIT   = 12;
	localparam int ST_VALID_BIT = 13;
	localparam int ST_FAULT_BIT = 14;
	localparam int ST_BUSY_BIT  = 15;

	localparam int SET_SWING_BIT = 0;
	localparam int SET_POS_BIT   = 1;
	localparam int SET_DDR_BIT   = 2;
	localparam int SET_CAL_BIT   = 3;
	localparam int SET_DES_BIT   = 4;
	localparam int SET_RANGE_BIT = 5;

	// ------------------------------------------------------------------
	// Setting values held outside the simple mode and after reset
	// ------------------------------------------------------------------
	localparam logic DEF_SWING_NORMAL = 1'b1;
	localparam logic DEF_EDGE_POS     = 1'b1;
	localparam logic DEF_DDR          = 1'b0;
	localparam logic DEF_CAL_LONG     = 1'b0;
	localparam logic DEF_DES          = 1'b0;
	localparam logic DEF_RANGE_NORMAL = 1'b1;
	localparam logic SEL_IDLE_N       = 1'b1;

endpackage : strap_pkg

// file: design/strap_if.sv
// Interface between the decoder core and its strap level resolver.
`timescale 1ns/1ns
interface strap_if;
	import strap_pkg::*;

	logic                start;
	logic [SETTLE_W-1:0] settle_cycles;
	logic                busy;
	logic                done;
	strap_levels_t       levels;

	modport ctrl (
		output start,
		output settle_cycles,
		input  busy,
		input  done,
		input  levels
	);

	modport sense (
		input  start,
		input  settle_cycles,
		output busy,
		output done,
		output levels
	);

endinterface : strap_if

// file: design/strap_level_resolver.sv
// Resolves each strap pin into driven low, driven high or floating.
`timescale 1ns/1ns
module strap_level_resolver (
	input  wire logic                          core_clk_i,
	input  wire logic                          arst_n_i,
	input  wire logic [strap_pkg::NUM_STRAPS-1:0] strap_pin_i,
	output logic                               strap_pull_up_o,
	strap_if.sense                             sns
);
	import strap_pkg::*;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef enum {
		SENSE_IDLE,
		SENSE_UP,
		SENSE_DOWN
	} sense_e;

	typedef struct packed {
		sense_e                  fsm;
		logic [SETTLE_W-1:0]     cnt;
		logic                    pull_up;
		logic [NUM_STRAPS-1:0]   up_snap;
		strap_levels_t           levels;
		logic                    done;
	} res_s;

	res_s st_r;
	res_s st_nxt;
	strap_levels_t level_calc;

	// ------------------------------------------------------------------
	// Classification
	// ------------------------------------------------------------------
	// A driven pin reads the same under both weak pulls; a floating pin
	// follows the pull. The impossible pair is treated as floating.
	genvar g;
	generate
		for (g = 0; g < NUM_STRAPS; g++)
		begin : g_class
			always_comb
			begin
				if (st_r.up_snap[g] == strap_pin_i[g])
					level_calc[g] = strap_pin_i[g] ? LVL_HIGH : LVL_LOW;
				else
					level_calc[g] = LVL_FLOAT;
			end
		end
	endgenerate

	always_comb
	begin
		st_nxt      = st_r;
		st_nxt.done = 1'b0;
		case (st_r.fsm)
			SENSE_IDLE:
				if (sns.start)
				begin
					st_nxt.pull_up = 1'b1;
					st_nxt.cnt     = sns.settle_cycles;
					st_nxt.fsm     = SENSE_UP;
				end
			SENSE_UP:
				if (st_r.cnt == SETTLE_ZERO)
				begin
					st_nxt.up_snap = strap_pin_i;
					st_nxt.pull_up = 1'b0;
					st_nxt.cnt     = sns.settle_cycles;
					st_nxt.fsm     = SENSE_DOWN;
				end
				else
					st_nxt.cnt = st_r.cnt - 1'b1;
			SENSE_DOWN:
				if (st_r.cnt == SETTLE_ZERO)
				begin
					st_nxt.levels  = level_calc;
					st_nxt.done    = 1'b1;
					st_nxt.pull_up = 1'b1;
					st_nxt.fsm     = SENSE_IDLE;
				end
				else
					st_nxt.cnt = st_r.cnt - 1'b1;
			default:
				st_nxt.fsm = SENSE_IDLE;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			st_r.fsm     <= SENSE_IDLE;
			st_r.cnt     <= SETTLE_ZERO;
			st_r.pull_up <= 1'b1;
			st_r.up_snap <= '0;
			st_r.levels  <= strap_levels_t'({NUM_STRAPS{LVL_FLOAT}});
			st_r.done    <= 1'b0;
		end
		else
			st_r <= st_nxt;
	end

	assign strap_pull_up_o = st_r.pull_up;
	assign sns.busy        = (st_r.fsm != SENSE_IDLE);
	assign sns.done        = st_r.done;
	assign sns.levels      = st_r.levels;

endmodule : strap_level_resolver

// file: design/control_mode_strap_decoder.sv
// Strap decoder: control mode, pin settings and serial port pin mux.
//
// Overview of operation
// - Floating primary, range driven: simple mode.
// - Swing pin: high normal, low reduced.
// - Edge pin high/low picks launch edge.
// - Floating edge pin selects double data rate.
// - Calibration pin: high long, low short.
// - Floating calibration pin: short delay, interleaving.
// - Secondary not low, primary low or floating with range floating: extended.
// - Extended mode: three pins become serial port.
// - Primary high forces simple mode always.
// - Range pin: high normal, low reduced.
`timescale 1ns/1ns
module control_mode_strap_decoder (
	input  wire logic                          core_clk_i,
	input  wire logic                          arst_n_i,
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [strap_pkg::WB_ADR_W-1:0] wb_adr_i,
	input  wire logic [strap_pkg::WB_SEL_W-1:0] wb_sel_i,
	input  wire logic [strap_pkg::WB_DAT_W-1:0] wb_dat_i,
	output logic      [strap_pkg::WB_DAT_W-1:0] wb_dat_o,
	output logic                               wb_ack_o,
	input  wire logic                          mode_primary_i,
	input  wire logic                          mode_secondary_i,
	input  wire logic                          input_range_pin_i,
	input  wire logic                          swing_pin_i,
	input  wire logic                          edge_pin_i,
	input  wire logic                          cal_pin_i,
	output logic                               strap_pull_up_o,
	output logic                               extended_mode_o,
	output logic                               serial_config_clk_o,
	output logic                               serial_config_data_o,
	output logic                               serial_config_select_n_o,
	output logic                               output_differential_swing_o,
	output logic                               output_launch_edge_select_o,
	output logic                               output_data_clock_ddr_o,
	output logic                               calibration_delay_select_o,
	output logic                               interleave_sampling_o,
	output logic                               input_full_scale_range_o,
	output logic                               strap_fault_o,
	output logic                               settings_valid_o
);
	import strap_pkg::*;

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic                start;
		logic [SETTLE_W-1:0] settle;
		logic                ack;
		logic [WB_DAT_W-1:0] rdata;
		logic                ext;
		logic                valid;
		logic                fault;
		logic                swing;
		logic                pos;
		logic                ddr;
		logic                cal_long;
		logic                des;
		logic                range;
		logic                ser_clk;
		logic                ser_data;
		logic                ser_sel_n;
	} dec_s;

	dec_s st_r;
	dec_s st_nxt;

	strap_if                 sif ();
	logic [NUM_STRAPS-1:0]   strap_pins;
	strap_level_e            lv_pri;
	strap_level_e            lv_sec;
	strap_level_e            lv_rng;
	strap_level_e            lv_swing;
	strap_level_e            lv_edge;
	strap_level_e            lv_cal;
	logic                    ext_calc;
	logic                    req;
	logic                    wr_lane0;
	logic [WB_DAT_W-1:0]     status_word;
	logic [WB_DAT_W-1:0]     settings_word;

	// ------------------------------------------------------------------
	// Level resolver
	// ------------------------------------------------------------------
	assign strap_pins[IDX_MODE_PRI] = mode_primary_i;
	assign strap_pins[IDX_MODE_SEC] = mode_secondary_i;
	assign strap_pins[IDX_RANGE]    = input_range_pin_i;
	assign strap_pins[IDX_SWING]    = swing_pin_i;
	assign strap_pins[IDX_EDGE]     = edge_pin_i;
	assign strap_pins[IDX_CAL]      = cal_pin_i;

	assign sif.start         = st_r.start;
	assign sif.settle_cycles = st_r.settle;

	strap_level_resolver u_resolver (
		.core_clk_i      (core_clk_i),
		.arst_n_i        (arst_n_i),
		.strap_pin_i     (strap_pins),
		.strap_pull_up_o (strap_pull_up_o),
		.sns             (sif.sense)
	);

	assign lv_pri   = sif.levels[IDX_MODE_PRI];
	assign lv_sec   = sif.levels[IDX_MODE_SEC];
	assign lv_rng   = sif.levels[IDX_RANGE];
	assign lv_swing = sif.levels[IDX_SWING];
	assign lv_edge  = sif.levels[IDX_EDGE];
	assign lv_cal   = sif.levels[IDX_CAL];

	// ------------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------------
	// A low secondary strap is outside every documented combination, so
	// the serial port stays shut there rather than guessing a mode.
	always_comb
	begin
		if (lv_pri == LVL_HIGH)
			ext_calc = 1'b0;
		else if (lv_sec == LVL_LOW)
			ext_calc = 1'b0;
		else if (lv_pri == LVL_LOW)
			ext_calc = 1'b1;
		else
			ext_calc = (lv_rng == LVL_FLOAT);
	end

	// ------------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------------
	assign req      = wb_cyc_i && wb_stb_i && !st_r.ack;
	assign wr_lane0 = req && wb_we_i && wb_sel_i[0];

	assign status_word = WB_DAT_W'({sif.busy, st_r.fault, st_r.valid,
		st_r.ext, sif.levels});

	always_comb
	begin
		settings_word                = '0;
		settings_word[SET_SWING_BIT] = st_r.swing;
		settings_word[SET_POS_BIT]   = st_r.pos;
		settings_word[SET_DDR_BIT]   = st_r.ddr;
		settings_word[SET_CAL_BIT]   = st_r.cal_long;
		settings_word[SET_DES_BIT]   = st_r.des;
		settings_word[SET_RANGE_BIT] = st_r.range;
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb
	begin
		st_nxt     = st_r;
		st_nxt.ack = req;

		// A request made while sensing waits until the resolver is idle.
		st_nxt.start = st_r.start && sif.busy;
		if (wr_lane0 && wb_adr_i == OFS_CTRL)
			st_nxt.start = st_nxt.start || wb_dat_i[CTRL_RESENSE_BIT];
		if (wr_lane0 && wb_adr_i == OFS_SETTLE)
			st_nxt.settle = wb_dat_i[SETTLE_W-1:0];

		if (req && !wb_we_i)
		begin
			case (wb_adr_i)
				OFS_STATUS:   st_nxt.rdata = status_word;
				OFS_SETTLE:   st_nxt.rdata = WB_DAT_W'(st_r.settle);
				OFS_SETTINGS: st_nxt.rdata = settings_word;
				default:      st_nxt.rdata = '0;
			endcase
		end

		if (sif.done)
		begin
			st_nxt.valid = 1'b1;
			st_nxt.ext   = ext_calc;
			if (ext_calc)
			begin
				// Settings belong to the serial registers in this mode.
				st_nxt.fault    = 1'b0;
				st_nxt.swing    = DEF_SWING_NORMAL;
				st_nxt.pos      = DEF_EDGE_POS;
				st_nxt.ddr      = DEF_DDR;
				st_nxt.cal_long = DEF_CAL_LONG;
				st_nxt.des      = DEF_DES;
				st_nxt.range    = DEF_RANGE_NORMAL;
			end
			else
			begin
				// A floating swing or range pin has no meaning here.
				st_nxt.fault    = (lv_swing == LVL_FLOAT) ||
					(lv_rng == LVL_FLOAT) || (lv_sec == LVL_LOW);
				st_nxt.swing    = (lv_swing != LVL_LOW);
				st_nxt.pos      = (lv_edge == LVL_HIGH);
				st_nxt.ddr      = (lv_edge == LVL_FLOAT);
				st_nxt.cal_long = (lv_cal == LVL_HIGH);
				st_nxt.des      = (lv_cal == LVL_FLOAT);
				st_nxt.range    = (lv_rng != LVL_LOW);
			end
		end

		// Serial port lines are only passed on while the extended mode
		// holds; otherwise the port sees an idle, deselected bus.
		if (st_r.ext)
		begin
			st_nxt.ser_clk   = swing_pin_i;
			st_nxt.ser_data  = edge_pin_i;
			st_nxt.ser_sel_n = cal_pin_i;
		end
		else
		begin
			st_nxt.ser_clk   = 1'b0;
			st_nxt.ser_data  = 1'b0;
			st_nxt.ser_sel_n = SEL_IDLE_N;
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	// The start flag resets high so the straps are sensed once after
	// every reset without software involvement.
	always_ff @(posedge core_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			st_r.start     <= 1'b1;
			st_r.settle    <= SETTLE_RST;
			st_r.ack       <= 1'b0;
			st_r.rdata     <= '0;
			st_r.ext       <= 1'b0;
			st_r.valid     <= 1'b0;
			st_r.fault     <= 1'b0;
			st_r.swing     <= DEF_SWING_NORMAL;
			st_r.pos       <= DEF_EDGE_POS;
			st_r.ddr       <= DEF_DDR;
			st_r.cal_long  <= DEF_CAL_LONG;
			st_r.des       <= DEF_DES;
			st_r.range     <= DEF_RANGE_NORMAL;
			st_r.ser_clk   <= 1'b0;
			st_r.ser_data  <= 1'b0;
			st_r.ser_sel_n <= SEL_IDLE_N;
		end
		else
			st_r <= st_nxt;
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign wb_dat_o                    = st_r.rdata;
	assign wb_ack_o                    = st_r.ack;
	assign extended_mode_o             = st_r.ext;
	assign serial_config_clk_o         = st_r.ser_clk;
	assign serial_config_data_o        = st_r.ser_data;
	assign serial_config_select_n_o    = st_r.ser_sel_n;
	assign output_differential_swing_o = st_r.swing;
	assign output_launch_edge_select_o = st_r.pos;
	assign output_data_clock_ddr_o     = st_r.ddr;
	assign calibration_delay_select_o  = st_r.cal_long;
	assign interleave_sampling_o       = st_r.des;
	assign input_full_scale_range_o    = st_r.range;
	assign strap_fault_o               = st_r.fault;
	assign settings_valid_o            = st_r.valid;

endmodule : control_mode_strap_decoder

// file: tb/strap_board.sv
// Board strap wiring model: each pin driven low, high or left floating.
`timescale 1ns/1ns
module strap_board (
	input  wire logic [11:0] level_i,
	input  wire logic        pull_up_i,
	output logic      [5:0]  pin_o
);
	import strap_pkg::*;
	// A floating pin settles to the weak pull the decoder applies, so the
	// model never holds the last driven level once a pin is released.
	always_comb
		for (int i = 0; i < NUM_STRAPS; i++)
			if (level_i[2*i +: 2] == 2'(LVL_FLOAT))
				pin_o[i] = pull_up_i;
			else
				pin_o[i] = level_i[2*i];
endmodule : strap_board

// file: tb/control_mode_strap_decoder_properties.sv
// Port checks of the strap decoder.
`timescale 1ns/1ns
module control_mode_strap_decoder_properties (
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	input wire logic wb_ack_o,
	input wire logic swing_pin_i,
	input wire logic edge_pin_i,
	input wire logic cal_pin_i,
	input wire logic extended_mode_o,
	input wire logic serial_config_clk_o,
	input wire logic serial_config_data_o,
	input wire logic serial_config_select_n_o,
	input wire logic output_differential_swing_o,
	input wire logic output_launch_edge_select_o,
	input wire logic output_data_clock_ddr_o,
	input wire logic calibration_delay_select_o,
	input wire logic interleave_sampling_o,
	input wire logic input_full_scale_range_o,
	input wire logic settings_valid_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	chk_serial_idle: assert property (
		!extended_mode_o && !$past(extended_mode_o) |-> !serial_config_clk_o
		&& !serial_config_data_o && serial_config_select_n_o)
		else $error("serial port active in simple mode");
	chk_serial_clock: assert property (
		extended_mode_o && $past(extended_mode_o) |->
		serial_config_clk_o == $past(swing_pin_i))
		else $error("serial clock not passed");
	chk_serial_data: assert property (
		extended_mode_o && $past(extended_mode_o) |->
		serial_config_data_o == $past(edge_pin_i) &&
		serial_config_select_n_o == $past(cal_pin_i))
		else $error("serial data or select not passed");
	chk_ext_defaults: assert property (extended_mode_o |->
		output_differential_swing_o && output_launch_edge_select_o &&
		!output_data_clock_ddr_o && !calibration_delay_select_o &&
		!interleave_sampling_o && input_full_scale_range_o)
		else $error("pin settings active in extended mode");
	chk_ddr_edge: assert property (
		output_data_clock_ddr_o |-> !output_launch_edge_select_o)
		else $error("edge select with double rate");
	chk_interleave_short: assert property (
		interleave_sampling_o |-> !calibration_delay_select_o)
		else $error("long delay with interleave");
	chk_valid_sticky: assert property (
		$past(settings_valid_o) |-> settings_valid_o)
		else $error("valid dropped");
endmodule : control_mode_strap_decoder_properties
bind control_mode_strap_decoder control_mode_strap_decoder_properties
	control_mode_strap_decoder_properties_i (
	.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .wb_ack_o(wb_ack_o),
	.swing_pin_i(swing_pin_i), .edge_pin_i(edge_pin_i), .cal_pin_i(cal_pin_i),
	.extended_mode_o(extended_mode_o),
	.serial_config_clk_o(serial_config_clk_o),
	.serial_config_data_o(serial_config_data_o),
	.serial_config_select_n_o(serial_config_select_n_o),
	.output_differential_swing_o(output_differential_swing_o),
	.output_launch_edge_select_o(output_launch_edge_select_o),
	.output_data_clock_ddr_o(output_data_clock_ddr_o),
	.calibration_delay_select_o(calibration_delay_select_o),
	.interleave_sampling_o(interleave_sampling_o),
	.input_full_scale_range_o(input_full_scale_range_o),
	.settings_valid_o(settings_valid_o));

// file: tb/control_mode_strap_decoder_tb.sv
// Self-checking bench of the strap decoder with a board strap model.
`timescale 1ns/1ns
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin \
	miscompares++; $display("ERROR %s expected %h seen %h", nm, e, s); end end
module control_mode_strap_decoder_tb;
	import strap_pkg::*;
	typedef struct {logic [31:0] d; logic [31:0] m; logic [7:0] p;} note_s;
	localparam logic [5:0] DEFS = {DEF_RANGE_NORMAL, DEF_DES, DEF_CAL_LONG,
		DEF_DDR, DEF_EDGE_POS, DEF_SWING_NORMAL};
	logic        core_clk_i = 1'b0;
	logic        arst_n_i = 1'b0;
	logic        cyc = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = '0;
	logic [31:0] wdat = '0;
	logic [31:0] rdat;
	logic [31:0] dat;
	logic [11:0] lvl = 12'h555;
	logic [5:0]  pin;
	logic [5:0]  sv;
	logic        pu, ack, ext, flt;
	logic [2:0]  ser;
	logic        vld;
	note_s       notes[$];
	note_s       nt;
	int          miscompares = 0;
	int          samples_checked = 0;
	int          rs;
	control_mode_strap_decoder control_mode_strap_decoder_i (
		.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack),
		.mode_primary_i(pin[IDX_MODE_PRI]), .mode_secondary_i(pin[IDX_MODE_SEC]),
		.input_range_pin_i(pin[IDX_RANGE]), .swing_pin_i(pin[IDX_SWING]),
		.edge_pin_i(pin[IDX_EDGE]), .cal_pin_i(pin[IDX_CAL]),
		.strap_pull_up_o(pu), .extended_mode_o(ext),
		.serial_config_clk_o(ser[2]), .serial_config_data_o(ser[1]),
		.serial_config_select_n_o(ser[0]),
		.output_differential_swing_o(sv[0]),
		.output_launch_edge_select_o(sv[1]), .output_data_clock_ddr_o(sv[2]),
		.calibration_delay_select_o(sv[3]), .interleave_sampling_o(sv[4]),
		.input_full_scale_range_o(sv[5]), .strap_fault_o(flt),
		.settings_valid_o(vld));
	strap_board strap_board_i (.level_i(lvl), .pull_up_i(pu), .pin_o(pin));
	initial
		forever #5 core_clk_i = ~core_clk_i;
	always @(posedge core_clk_i)
		if (ack === 1'b1 && we === 1'b0 && notes.size() > 0)
		begin
			nt = notes.pop_front();
			`CHK("read data", nt.d, dat & nt.m)
			`CHK("outputs", nt.p, {ext, flt, sv})
		end
	task automatic stop_test();
		$display("checked %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	// The request stays up until ack is sampled, then drops for one cycle.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
		begin
			@(posedge core_clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 50);
		rdat = dat;
		cyc <= 1'b0;
		we <= 1'b0;
		if (n >= 50)
		begin
			miscompares++;
			stop_test();
		end
		@(posedge core_clk_i);
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [7:0] p);
		notes.push_back('{e, '1, p});
		wb(1'b0, a, '0);
	endtask : rd
	// Busy may not have risen yet at the first look, so a fresh sense must be
	// seen busy once before idle counts.
	task automatic poll(input bit need);
		int n;
		bit seen;
		n = 0;
		seen = !need;
		do
		begin
			wb(1'b0, OFS_STATUS, '0);
			seen |= rdat[ST_BUSY_BIT] === 1'b1;
			n++;
		end
		while (!(seen && rdat[ST_BUSY_BIT] === 1'b0 &&
			rdat[ST_VALID_BIT] === 1'b1) && n < 200);
		if (n >= 200)
		begin
			miscompares++;
			stop_test();
		end
	endtask : poll
	task automatic sense(input logic [11:0] l);
		logic [1:0] p, s2, r, w, e, c;
		logic x, f;
		logic [5:0] s;
		{c, e, w, r, s2, p} = l;
		x = p != LVL_HIGH && s2 != LVL_LOW && (p == LVL_LOW || r == LVL_FLOAT);
		f = !x && (w == LVL_FLOAT || r == LVL_FLOAT || s2 == LVL_LOW);
		s = {r != LVL_LOW, c == LVL_FLOAT, c == LVL_HIGH, e == LVL_FLOAT,
			e == LVL_HIGH, w != LVL_LOW};
		if (x)
			s = DEFS;
		lvl <= l;
		wb(1'b1, OFS_CTRL, 32'h1);
		poll(1'b1);
		notes.push_back('{{16'h0, 1'b0, f, 1'b1, x, l}, 32'hffff, {x, f, s}});
		wb(1'b0, OFS_STATUS, '0);
		rd(OFS_SETTINGS, {26'h0, s}, {x, f, s});
	endtask : sense
	initial
	begin
		logic [7:0] st;
		logic [2:0] e1;
		logic [2:0] e2;
		static logic [11:0] tbl [7] = '{12'h555, 12'h00a, 12'ha56, 12'h558,
			12'h02a, 12'haa9, 12'h552};
		rs = $urandom(32'h6a4121e7);
		repeat (2) @(posedge core_clk_i);
		arst_n_i <= 1'b1;
		@(posedge core_clk_i);
		rd(OFS_SETTLE, {24'h0, SETTLE_RST}, {2'b0, DEFS});
		rd(8'h10, 32'h0, {2'b0, DEFS});
		rd(OFS_CTRL, 32'h0, {2'b0, DEFS});
		poll(1'b0);
		st = 8'($urandom_range(8, 2));
		wb(1'b1, OFS_SETTLE, {24'h0, st});
		wb(1'b1, OFS_SETTINGS, '1);
		// All straps high at power-up: simple mode, normal, positive, long.
		rd(OFS_SETTLE, {24'h0, st}, 8'h2b);
		$display("test registers done");
		foreach (tbl[i])
			sense(tbl[i]);
		repeat (12)
			sense({6{2'($urandom_range(2))}} ^ 12'($urandom) & 12'h000);
		for (int k = 0; k < 12; k++)
			sense({2'($urandom_range(2)), 2'($urandom_range(2)),
				2'($urandom_range(2)), 2'($urandom_range(2)),
				2'($urandom_range(2)), 2'($urandom_range(2))});
		$display("test strap decode done");
		sense(12'h558);
		// A pin set at one edge is sampled at the next and shows on the
		// serial outputs one edge later still.
		e1 = 3'b111;
		e2 = 3'b111;
		repeat (40)
		begin
			@(posedge core_clk_i);
			`CHK("serial pins", e2, ser)
			`CHK("settings valid", 1'b1, vld)
			e2 = e1;
			rs = $urandom;
			e1 = {rs[0], rs[1], rs[2]};
			lvl[11:6] <= {1'b0, rs[2], 1'b0, rs[1], 1'b0, rs[0]};
		end
		$display("test serial pins done");
		stop_test();
	end
endmodule : control_mode_strap_decoder_tb
